// ==== dv/host_model.sv ====
// Host model driving the transmit-off pin
`timescale 1ns/1ps
module host_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bench commands
  input wire logic off_lvl,
  input wire logic clr,
  // Module pin
  output logic     tx_off_req
);
  logic [7:0] hold_reg;
  // Clear pulse held 101 cycles; serial clock never runs
  always_ff @(posedge ref_clk) begin
    if (rst || clr)
      hold_reg <= rst ? 8'h00 : 8'h65;
    else if (hold_reg != 8'h00)
      hold_reg <= hold_reg - 8'h01;
  end
  assign tx_off_req = off_lvl | (hold_reg != 8'h00);
endmodule

// ==== dv/optical_module_ctrl_checker.sv ====
// Timing checker for the module control logic
`timescale 1ns/1ps
module optical_module_ctrl_checker #(parameter int INIT_CYCLES = 200) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Pins
  input wire logic       tx_off_req,
  input wire logic       laser_fault,
  input wire logic [7:0] rx_level,
  input wire logic       tx_fault,
  input wire logic       receive_signal_lost,
  input wire logic       laser_enable,
  input wire logic       init_done
);
  localparam int LIM = INIT_CYCLES + 20;
  logic [10:0] lo_n, hi_n, mid_n, on_n, idle_n;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Run lengths; wrap is harmless in short runs
  always_ff @(posedge ref_clk) begin
    lo_n <= rst || rx_level > 8'h3f ? 11'd0 : lo_n + 11'd1;
    hi_n <= rst || rx_level < 8'h48 ? 11'd0 : hi_n + 11'd1;
    mid_n <= rst || lo_n != 0 || hi_n != 0 ? 11'd0 : mid_n + 11'd1;
    on_n <= rst || !tx_off_req ? 11'd0 : on_n + 11'd1;
    idle_n <= rst || tx_off_req ? 11'd0 : idle_n + 11'd1;
  end
  sequence s_ready;
    ##[1:LIM] init_done && !tx_fault;
  endsequence
  a_laser_off: assert property (
    $rose(tx_off_req) |-> ##[1:100] !laser_enable) else $error("slow off");
  a_laser_on: assert property (
    $fell(tx_off_req) && !laser_fault && !tx_fault |-> ##[1:1000] laser_enable)
    else $error("slow on");
  a_init_time: assert property (
    ($fell(rst) || $fell(tx_off_req) && on_n > 11'd100) && !laser_fault
    |-> s_ready) else $error("slow init");
  a_fault_flag: assert property (
    $rose(laser_fault) && init_done && !tx_off_req |-> ##[1:1000] tx_fault)
    else $error("slow fault");
  a_loss_set: assert property (
    lo_n == 11'd1000 |-> receive_signal_lost) else $error("loss not set");
  a_loss_clear: assert property (
    hi_n == 11'd1000 |-> !receive_signal_lost) else $error("loss stuck");
  a_loss_hyst: assert property (
    mid_n > 11'd20 |-> $stable(receive_signal_lost)) else $error("no hyst");
  a_fault_held: assert property (
    tx_fault && (tx_off_req || idle_n > LIM) |=> tx_fault)
    else $error("fault lost");
endmodule
bind optical_module_ctrl optical_module_ctrl_checker #(
  .INIT_CYCLES(INIT_CYCLES)) u_chk (.ref_clk(ref_clk), .rst(rst),
  .tx_off_req(tx_off_req), .laser_fault(laser_fault), .rx_level(rx_level),
  .tx_fault(tx_fault), .receive_signal_lost(receive_signal_lost),
  .laser_enable(laser_enable), .init_done(init_done));

// ==== dv/tb_optical_module_tx_rx_status_control.sv ====
// Bench for the module control logic
`timescale 1ns/1ps
module tb_optical_module_tx_rx_status_control;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       off_lvl = 1'b0;
  logic       clr = 1'b0;
  logic       laser_fault = 1'b0;
  logic [7:0] rx_level = 8'h60;
  logic       tx_off_req, tx_fault, lost, laser_enable, init_done;
  logic [3:0] o;
  int         bad_count = 0;
  int         checked = 0;
  // Off, level, expected loss, laser and run
  logic [15:0] rows [5] = '{16'h03f7, 16'h1414, 16'h0493, 16'h0413, 16'h13f4};
  assign o = {init_done, laser_enable, lost, tx_fault};
  always #50 ref_clk = ~ref_clk;
  host_model u_host (.ref_clk(ref_clk), .rst(rst), .off_lvl(off_lvl),
    .clr(clr), .tx_off_req(tx_off_req));
  optical_module_ctrl #(.INIT_CYCLES(200), .ON_CYCLES(50), .FILT_CYCLES(10),
    .RESET_CYCLES(100)) u_dut (.ref_clk(ref_clk), .rst(rst),
    .tx_off_req(tx_off_req), .tx_fault(tx_fault), .laser_fault(laser_fault),
    .receive_signal_lost(lost), .rx_level(rx_level),
    .laser_enable(laser_enable), .init_done(init_done));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait on one output flag
  task automatic wt(input int s, input logic v, input int lim);
    for (int i = 0; i < lim && o[s] !== v; i++) tick(1);
    chk($sformatf("flag%0d", s), v, o[s]);
    if (o[s] !== v) end_sim();
  endtask
  initial begin
    tick(4);
    rst = 1'b0;
    wt(3, 1'b1, 250);
    foreach (rows[i]) begin
      off_lvl = rows[i][12];
      rx_level = rows[i][11:4];
      tick(1100);
      chk("row", rows[i][2:0], {o[1], o[2], o[3]});
    end
    off_lvl = 1'b0;
    rst = 1'b1;
    tick(4);
    chk("rst", 4'h2, o);
    rst = 1'b0;
    wt(3, 1'b1, 250);
    laser_fault = 1'b1;
    wt(0, 1'b1, 1000);
    laser_fault = 1'b0;
    tick(300);
    chk("hold", 1'b1, tx_fault);
    off_lvl = 1'b1;
    tick(50);
    off_lvl = 1'b0;
    tick(300);
    chk("short", 1'b1, tx_fault);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    wt(0, 1'b0, 400);
    wt(3, 1'b1, 300);
    end_sim();
  end
endmodule

// ==== rtl/optical_module_ctrl.sv ====
// Transmit control, fault latch and receive loss detection of the module
`timescale 1ns/1ps
`include "optical_module_params.svh"
module optical_module_ctrl #(
  parameter int INIT_CYCLES  = `INIT_CYC,
  parameter int ON_CYCLES    = `ON_CYC,
  parameter int FILT_CYCLES  = `LOSS_CYC / 2,
  parameter int RESET_CYCLES = `RESET_CYC,
  parameter int LEVEL_W      = `LEVEL_W,
  parameter logic [LEVEL_W-1:0] LOS_SET_LEVEL   = 8'h40,
  parameter logic [LEVEL_W-1:0] LOS_CLEAR_LEVEL = 8'h48
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Host pins
  input  wire logic               tx_off_req,
  output logic                    tx_fault,
  output logic                    receive_signal_lost,
  // Analog front end
  input  wire logic               laser_fault,
  input  wire logic [LEVEL_W-1:0] rx_level,
  output logic                    laser_enable,
  output logic                    init_done
);
  localparam int CW = 22;
  // Clear level must exceed set level for hysteresis
  localparam logic [LEVEL_W-1:0] LOS_CLR = (LOS_CLEAR_LEVEL > LOS_SET_LEVEL) ?
    LOS_CLEAR_LEVEL : LOS_SET_LEVEL + 1'b1;

  localparam int SW = LEVEL_W + 2;
  // Off request resets high so the laser stays dark until the pin is seen
  localparam logic [SW-1:0] SYNC_INIT = {1'b1, 1'b0, {LEVEL_W{1'b0}}};

  logic [SW-1:0]      pin_in;
  logic [SW-1:0]      sync_s1_reg;
  logic [SW-1:0]      sync_reg;
  logic               off_reg;
  logic               flt_reg;
  logic [LEVEL_W-1:0] lvl_reg;
  optical_module_pkg::tx_state_e state_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] hold_reg;
  logic       clr_armed_reg;
  logic       los_raw_reg;
  logic [CW-1:0] los_cnt_reg;

  // Pin synchronisers, one pair of flip-flops per pin bit
  assign pin_in = {tx_off_req, laser_fault, rx_level};

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          sync_s1_reg[gi] <= SYNC_INIT[gi];
          sync_reg[gi]    <= SYNC_INIT[gi];
        end else begin
          sync_s1_reg[gi] <= pin_in[gi];
          sync_reg[gi]    <= sync_s1_reg[gi];
        end
      end
    end
  endgenerate

  // Level bits are sampled one by one; the debounce filter
  // hides the odd mixed code while the level moves
  assign off_reg = sync_reg[SW-1];
  assign flt_reg = sync_reg[SW-2];
  assign lvl_reg = sync_reg[LEVEL_W-1:0];

  // Off request held long enough arms a fault clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_reg      <= '0;
      clr_armed_reg <= 1'b0;
    end else if (off_reg) begin
      if (hold_reg < CW'(RESET_CYCLES))
        hold_reg <= hold_reg + 1'b1;
      else
        clr_armed_reg <= 1'b1;
    end else begin
      hold_reg      <= '0;
      clr_armed_reg <= 1'b0;
    end
  end

  // Transmit state machine
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= optical_module_pkg::ST_INIT;
      cnt_reg   <= '0;
    end else begin
      case (state_reg)
        optical_module_pkg::ST_INIT: begin
          if (flt_reg) begin
            state_reg <= optical_module_pkg::ST_FAULT;
          end else if (off_reg) begin
            state_reg <= optical_module_pkg::ST_OFF;
          end else if (cnt_reg >= CW'(INIT_CYCLES - 1)) begin
            state_reg <= optical_module_pkg::ST_RUN;
          end else if (cnt_reg >= CW'(ON_CYCLES - 1)) begin
            cnt_reg <= cnt_reg + 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        optical_module_pkg::ST_RUN: begin
          if (flt_reg)
            state_reg <= optical_module_pkg::ST_FAULT;
          else if (off_reg)
            state_reg <= optical_module_pkg::ST_OFF;
        end
        optical_module_pkg::ST_OFF: begin
          if (!off_reg) begin
            state_reg <= optical_module_pkg::ST_INIT;
            cnt_reg   <= '0;
          end
        end
        optical_module_pkg::ST_FAULT: begin
          // Only a qualifying off pulse leaves the latched fault
          if (!off_reg && clr_armed_reg) begin
            state_reg <= optical_module_pkg::ST_INIT;
            cnt_reg   <= '0;
          end
        end
        default: begin
          state_reg <= optical_module_pkg::ST_INIT;
          cnt_reg   <= '0;
        end
      endcase
    end
  end

  // Laser drive; off at once in off, fault and while requested
  always_ff @(posedge ref_clk) begin
    if (rst)
      laser_enable <= 1'b0;
    else
      laser_enable <= !off_reg && !flt_reg &&
        ((state_reg == optical_module_pkg::ST_RUN) ||
         ((state_reg == optical_module_pkg::ST_INIT) &&
          (cnt_reg < CW'(ON_CYCLES - 1))));
  end

  // Fault and init status
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_fault  <= 1'b0;
      init_done <= 1'b0;
    end else begin
      tx_fault  <= (state_reg == optical_module_pkg::ST_FAULT);
      init_done <= (state_reg == optical_module_pkg::ST_RUN);
    end
  end

  // Loss comparator with hysteresis
  always_ff @(posedge ref_clk) begin
    if (rst)
      los_raw_reg <= 1'b1;
    else if (lvl_reg < LOS_SET_LEVEL)
      los_raw_reg <= 1'b1;
    else if (lvl_reg >= LOS_CLR)
      los_raw_reg <= 1'b0;
  end

  // Debounce filter; half the allowed time leaves margin for sync delay
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      los_cnt_reg         <= '0;
      receive_signal_lost <= 1'b1;
    end else if (los_raw_reg == receive_signal_lost) begin
      los_cnt_reg <= '0;
    end else if (los_cnt_reg >= CW'(FILT_CYCLES - 1)) begin
      los_cnt_reg         <= '0;
      receive_signal_lost <= los_raw_reg;
    end else begin
      los_cnt_reg <= los_cnt_reg + 1'b1;
    end
  end
endmodule

// ==== rtl/optical_module_params.svh ====
// Constants for the optical module control and status logic
`ifndef OPTICAL_MODULE_PARAMS_SVH
`define OPTICAL_MODULE_PARAMS_SVH
`define CLK_FREQ_HZ        10000000
`define T_OFF_US           10
`define T_ON_US            1000
`define T_INIT_MS          300
`define T_FAULT_US         100
`define T_RESET_US         10
`define T_LOSS_US          100
`define F_SERIAL_MAX_HZ    100000
`define HYST_TENTH_DB      5
`define LEVEL_W            8
// Cycle counts derived from the clock rate
`define OFF_CYC   (`T_OFF_US * (`CLK_FREQ_HZ / 1000000))
`define ON_CYC    (`T_ON_US * (`CLK_FREQ_HZ / 1000000))
`define INIT_CYC  (`T_INIT_MS * (`CLK_FREQ_HZ / 1000))
`define FAULT_CYC (`T_FAULT_US * (`CLK_FREQ_HZ / 1000000))
`define RESET_CYC (`T_RESET_US * (`CLK_FREQ_HZ / 1000000))
`define LOSS_CYC  (`T_LOSS_US * (`CLK_FREQ_HZ / 1000000))
`endif

// ==== rtl/optical_module_pkg.sv ====
// Types for the optical module control and status logic
package optical_module_pkg;
  typedef enum logic [3:0] {
    ST_INIT  = 4'b0001,
    ST_RUN   = 4'b0010,
    ST_OFF   = 4'b0100,
    ST_FAULT = 4'b1000
  } tx_state_e;
endpackage
